// ===== wsrs_cfg.svh
// wsrs_cfg.svh: named constants of the wake/sleep rate selection block.
// assumes inclusion by bare name from the wsrs decode, pulse stretch and rate select files.
`ifndef WSRS_CFG_SVH
`define WSRS_CFG_SVH

// ****************************************************************
// register indexes (byte address is four times the index)
// ****************************************************************
`define WSRS_IDX_SENSOR_CTRL   8'h15
`define WSRS_IDX_POWER_CFG     8'h16
`define WSRS_IDX_RATE_SEL      8'h17
`define WSRS_IDX_INT_CFG       8'h18
`define WSRS_IDX_WAKE_IDLE_LSB 8'h30
`define WSRS_IDX_WAKE_IDLE_MSB 8'h31
`define WSRS_IDX_SLP_IDLE_LSB  8'h32
`define WSRS_IDX_SLP_IDLE_MSB  8'h33
`define WSRS_IDX_STATUS        8'h34
`define WSRS_IDX_NONE          8'hFF

// ****************************************************************
// field positions
// ****************************************************************
`define WSRS_WAKE_NIB_HI       7
`define WSRS_WAKE_NIB_LO       4
`define WSRS_SLP_NIB_HI        3
`define WSRS_SLP_NIB_LO        0
`define WSRS_WAKE_POWER_SEL_HI        7
`define WSRS_WAKE_POWER_SEL_LO        6
`define WSRS_SLP_PM_HI         5
`define WSRS_SLP_PM_LO         4
`define WSRS_PM_FLEX_BIT       1
`define WSRS_PM_HPERF_BIT      0
`define WSRS_CTRL_ACTIVE_BIT   0
`define WSRS_CTRL_SAMPLE_READY_EVENT_EN_BIT  1
`define WSRS_IDLE_MSB_HI       3
`define WSRS_CODE_MAX          4'hC

// ****************************************************************
// reset values
// ****************************************************************
`define WSRS_RATE_RST_GND      8'h00
`define WSRS_RATE_RST_VDD      8'hC0
`define WSRS_INT_CFG_RST       8'h01
`define WSRS_BYTE_ZERO         8'h00
`define WSRS_STRAP_SETTLE      2'h2
`define WSRS_STRAP_DONE        2'h3

// ****************************************************************
// timing: times in ns, cycles derived from the clock rate
// ****************************************************************
`define WSRS_CLK_MHZ           100
`define WSRS_BASE_TIME_NS      312500
`define WSRS_FIRST_TIME_NS     528500
`define WSRS_GAP_TIME_NS       500000
`define WSRS_PULSE_TIME_NS     5000000
`define WSRS_STEP_SCALE_NUM    9984
`define WSRS_STEP_SCALE_DEN    10000
`define WSRS_NS_PER_US         1000

`endif

// ===== wsrs_pkg.sv
// wsrs_pkg.sv: types shared by the wake/sleep rate selection block.
// assumes nothing of its surroundings.
package wsrs_pkg;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        WSRS_SEQ_IDLE  = 3'b000,   // standby, no acquisition
        WSRS_SEQ_LOAD  = 3'b001,   // latch settings of current state
        WSRS_SEQ_FIRST = 3'b010,   // waiting for first sample
        WSRS_SEQ_RUN   = 3'b011,   // steady sampling
        WSRS_SEQ_GAP   = 3'b100    // wake/sleep changeover gap
    } wsrs_seq_type;

endpackage : wsrs_pkg

// ===== wsrs_rate_decode.sv
// wsrs_rate_decode.sv: turns one nibble plus power mode into decimation
// and sample period in base units of 312.5 us.
// assumes a stable nibble, mode and idle time from the register file.
`timescale 1ns/100ps
`include "wsrs_cfg.svh"

module wsrs_rate_decode
    import wsrs_pkg::*;
(
    // settings of one state
    input  wire logic [3:0]  code_in,
    input  wire logic [1:0]  power_sel_in,
    input  wire logic [11:0] idle_in,
    // decoded timing
    output logic      [12:0] decim_out,
    output logic      [24:0] units_out,
    output logic             fast_start_out
);

    logic [3:0] step_exp;   // code clamped to top entry

    // ****************************************************************
    // decode
    // ****************************************************************
    // mode picks the meaning of the nibble
    always_comb begin
        step_exp = (code_in > `WSRS_CODE_MAX) ? `WSRS_CODE_MAX : code_in;
        if (power_sel_in[`WSRS_PM_FLEX_BIT]) begin
            decim_out      = 13'(13'h1 << step_exp);
            units_out      = 25'((25'(idle_in) + 25'h1) << step_exp);
            fast_start_out = (idle_in == 12'h0);
        end else if (power_sel_in[`WSRS_PM_HPERF_BIT]) begin
            decim_out      = 13'(13'h1 << step_exp);
            units_out      = 25'(25'h1 << step_exp);
            fast_start_out = (step_exp == 4'h0);
        end else begin
            // low power: decimation fixed at one
            decim_out      = 13'h1;
            units_out      = 25'(25'h1 << step_exp);
            fast_start_out = (step_exp == 4'h0);
        end
    end

endmodule : wsrs_rate_decode

// ===== wsrs_pulse_stretch.sv
// wsrs_pulse_stretch.sv: active-low interrupt pulse, stretched or not.
// assumes trigger comes from logic on the same clock.
`timescale 1ns/100ps
`include "wsrs_cfg.svh"

module wsrs_pulse_stretch
    import wsrs_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = 500000
)(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // control
    input  wire logic trig_in,
    input  wire logic stretch_en_in,
    // pin
    output logic      pulse_n_out
);

    logic [31:0] left_r;    // cycles of low pulse remaining
    logic [31:0] left_nxt;
    logic        pin_n_r;   // registered pin level
    logic        pin_n_nxt;

    // ****************************************************************
    // next state
    // ****************************************************************
    // a new trigger restarts the count, so close pulses merge
    always_comb begin
        left_nxt = (left_r != 32'h0) ? left_r - 32'h1 : left_r;
        if (trig_in) begin
            left_nxt = stretch_en_in ? 32'(PULSE_CYCLES) : 32'h1;
        end
        pin_n_nxt = (left_nxt == 32'h0);
    end

    // registers only
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            left_r  <= 32'h0;
            pin_n_r <= 1'b1;
        end else begin
            left_r  <= left_nxt;
            pin_n_r <= pin_n_nxt;
        end
    end

    assign pulse_n_out = pin_n_r;

endmodule : wsrs_pulse_stretch

// ===== wsrs_rate_select.sv
// wsrs_rate_select.sv: wake/sleep rate and decimation selection with
// its acquisition pacing, behind an AHB-Lite register slave.
// assumes a single AHB-Lite master, boot strap on a pin, and the
// wake/sleep state coming from logic on the same clock.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "wsrs_cfg.svh"

module wsrs_rate_select
    import wsrs_pkg::*;
#(
    parameter int unsigned BASE_CYCLES  = (`WSRS_BASE_TIME_NS * `WSRS_CLK_MHZ) / `WSRS_NS_PER_US,
    parameter int unsigned STEP_CYCLES  = (BASE_CYCLES * `WSRS_STEP_SCALE_NUM)
                                          / `WSRS_STEP_SCALE_DEN,
    parameter int unsigned FIRST_CYCLES = (`WSRS_FIRST_TIME_NS * `WSRS_CLK_MHZ) / `WSRS_NS_PER_US,
    parameter int unsigned GAP_CYCLES   = (`WSRS_GAP_TIME_NS * `WSRS_CLK_MHZ) / `WSRS_NS_PER_US,
    parameter int unsigned PULSE_CYCLES = (`WSRS_PULSE_TIME_NS * `WSRS_CLK_MHZ) / `WSRS_NS_PER_US
)(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    // device pins and state
    input  wire logic        boot_select_pin_in,
    input  wire logic        sleep_state_in,
    output logic             interrupt_line_one_n_out,
    // acquisition pacing
    output logic             sample_ready_event_out,
    output logic             acquiring_out,
    output logic [12:0]      cur_decim_out
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [7:0]   ctrl_r, ctrl_nxt;            // active, data-ready enable
    logic [7:0]   power_r, power_nxt;          // power mode per state
    logic [7:0]   rate_r, rate_nxt;            // rate/decimation nibbles
    logic [7:0]   intcfg_r, intcfg_nxt;        // interrupt config, stored
    logic [11:0]  wake_idle_r, wake_idle_nxt;  // wake idle time
    logic [11:0]  slp_idle_r, slp_idle_nxt;    // sleep idle time
    logic         wr_pend_r, wr_pend_nxt;      // write data phase due
    logic [7:0]   wr_idx_r, wr_idx_nxt;        // index of pending write
    logic [31:0]  rdata_r, rdata_nxt;          // read data register
    logic         boot_meta_r, boot_sync_r;    // strap synchroniser
    logic [1:0]   strap_cnt_r, strap_cnt_nxt;  // strap settle counter
    logic         strap_r, strap_nxt;          // caught strap level
    logic         sw_wrote_r, sw_wrote_nxt;    // software beat the strap
    wsrs_seq_type seq_r, seq_nxt;              // sequencer state
    logic         applied_slp_r, applied_slp_nxt; // state in use
    logic [39:0]  count_r, count_nxt;          // cycles to next event
    logic         sample_r, sample_nxt;        // one-cycle sample strobe
    logic [12:0]  decim_r, decim_nxt;          // decimation in use
    logic         ahb_take;                    // address phase accepted
    logic [7:0]   take_idx;                    // decoded index
    logic [3:0]   sel_code;                    // nibble of applied state
    logic [1:0]   sel_pm;                      // power select of state
    logic [11:0]  sel_idle;                    // idle of applied state
    logic [12:0]  dec_decim;                   // decoded decimation
    logic [24:0]  dec_units;                   // decoded period units
    logic         dec_fast;                    // first-sample delay applies, not the period
    logic [39:0]  period_cyc;                  // sample period in cycles
    logic [39:0]  first_cyc;                   // first-sample delay

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // byte address to register index, none if misaligned or at 0x400 and above
    function automatic logic [7:0] addr_to_idx(input logic [31:0] addr);
        logic [7:0] idx;
        idx = `WSRS_IDX_NONE;
        if (addr[1:0] == 2'h0 && addr[31:10] == 22'h0) begin
            idx = addr[9:2];
        end
        return idx;
    endfunction : addr_to_idx

    // ****************************************************************
    // ahb-lite slave
    // ****************************************************************
    // zero wait states; reads look at next values so a read right
    // after a write to the same register sees the new byte
    assign ahb_take      = hsel_in & htrans_in[1] & hready_in;
    assign take_idx      = addr_to_idx(haddr_in);
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata_r;

    // register file and strap capture
    always_comb begin
        ctrl_nxt      = ctrl_r;
        power_nxt     = power_r;
        rate_nxt      = rate_r;
        intcfg_nxt    = intcfg_r;
        wake_idle_nxt = wake_idle_r;
        slp_idle_nxt  = slp_idle_r;
        strap_cnt_nxt = strap_cnt_r;
        strap_nxt     = strap_r;
        sw_wrote_nxt  = sw_wrote_r;
        wr_pend_nxt   = ahb_take & hwrite_in;
        wr_idx_nxt    = ahb_take ? take_idx : wr_idx_r;
        rdata_nxt     = rdata_r;
        // strap settles through the synchroniser first
        if (strap_cnt_r != `WSRS_STRAP_DONE) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
        end
        if (strap_cnt_r == `WSRS_STRAP_SETTLE) begin
            strap_nxt = boot_sync_r;
            if (!sw_wrote_r) begin
                rate_nxt = boot_sync_r ? `WSRS_RATE_RST_VDD : `WSRS_RATE_RST_GND;
            end
        end
        // data phase of a write; hsize unused, byte lane 0 only
        if (wr_pend_r) begin
            unique case (wr_idx_r)
                `WSRS_IDX_SENSOR_CTRL:   ctrl_nxt   = hwdata_in[7:0];
                `WSRS_IDX_POWER_CFG:     power_nxt  = hwdata_in[7:0];
                `WSRS_IDX_RATE_SEL: begin
                    rate_nxt     = hwdata_in[7:0];
                    sw_wrote_nxt = 1'b1;
                end
                `WSRS_IDX_INT_CFG:       intcfg_nxt = hwdata_in[7:0];
                `WSRS_IDX_WAKE_IDLE_LSB: wake_idle_nxt[7:0]  = hwdata_in[7:0];
                `WSRS_IDX_WAKE_IDLE_MSB: wake_idle_nxt[11:8] =
                                         hwdata_in[`WSRS_IDLE_MSB_HI:0];
                `WSRS_IDX_SLP_IDLE_LSB:  slp_idle_nxt[7:0]   = hwdata_in[7:0];
                `WSRS_IDX_SLP_IDLE_MSB:  slp_idle_nxt[11:8]  =
                                         hwdata_in[`WSRS_IDLE_MSB_HI:0];
                // status, unmapped: write ignored
                default: ;
            endcase
        end
        // read value captured in the address phase
        if (ahb_take && !hwrite_in) begin
            unique case (take_idx)
                `WSRS_IDX_SENSOR_CTRL:   rdata_nxt = {24'h0, ctrl_nxt};
                `WSRS_IDX_POWER_CFG:     rdata_nxt = {24'h0, power_nxt};
                `WSRS_IDX_RATE_SEL:      rdata_nxt = {24'h0, rate_nxt};
                `WSRS_IDX_INT_CFG:       rdata_nxt = {24'h0, intcfg_nxt};
                `WSRS_IDX_WAKE_IDLE_LSB: rdata_nxt = {24'h0, wake_idle_nxt[7:0]};
                `WSRS_IDX_WAKE_IDLE_MSB: rdata_nxt = {28'h0, wake_idle_nxt[11:8]};
                `WSRS_IDX_SLP_IDLE_LSB:  rdata_nxt = {24'h0, slp_idle_nxt[7:0]};
                `WSRS_IDX_SLP_IDLE_MSB:  rdata_nxt = {28'h0, slp_idle_nxt[11:8]};
                `WSRS_IDX_STATUS:        rdata_nxt = {26'h0, strap_r, applied_slp_r,
                                                      acquiring_out, seq_r};
                default:                 rdata_nxt = 32'h0;
            endcase
        end
    end

    // register file flip-flops; constants only under reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_r      <= `WSRS_BYTE_ZERO;
            power_r     <= `WSRS_BYTE_ZERO;
            rate_r      <= `WSRS_RATE_RST_GND;
            intcfg_r    <= `WSRS_INT_CFG_RST;
            wake_idle_r <= 12'h0;
            slp_idle_r  <= 12'h0;
            wr_pend_r   <= 1'b0;
            wr_idx_r    <= `WSRS_IDX_NONE;
            rdata_r     <= 32'h0;
            boot_meta_r <= 1'b0;
            boot_sync_r <= 1'b0;
            strap_cnt_r <= 2'h0;
            strap_r     <= 1'b0;
            sw_wrote_r  <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            power_r     <= power_nxt;
            rate_r      <= rate_nxt;
            intcfg_r    <= intcfg_nxt;
            wake_idle_r <= wake_idle_nxt;
            slp_idle_r  <= slp_idle_nxt;
            wr_pend_r   <= wr_pend_nxt;
            wr_idx_r    <= wr_idx_nxt;
            rdata_r     <= rdata_nxt;
            boot_meta_r <= boot_select_pin_in;
            boot_sync_r <= boot_meta_r;
            strap_cnt_r <= strap_cnt_nxt;
            strap_r     <= strap_nxt;
            sw_wrote_r  <= sw_wrote_nxt;
        end
    end

    // ****************************************************************
    // settings of the applied state
    // ****************************************************************
    // upper nibble in wake, lower in sleep
    assign sel_code = applied_slp_r ? rate_r[`WSRS_SLP_NIB_HI:`WSRS_SLP_NIB_LO]
                                    : rate_r[`WSRS_WAKE_NIB_HI:`WSRS_WAKE_NIB_LO];
    assign sel_pm   = applied_slp_r ? power_r[`WSRS_SLP_PM_HI:`WSRS_SLP_PM_LO]
                                    : power_r[`WSRS_WAKE_POWER_SEL_HI:`WSRS_WAKE_POWER_SEL_LO];
    // idle of the state in use
    assign sel_idle = applied_slp_r ? slp_idle_r : wake_idle_r;

    // decimation implied by the mode and code
    wsrs_rate_decode u_decode (
        .code_in        (sel_code),
        .power_sel_in   (sel_pm),
        .idle_in        (sel_idle),
        .decim_out      (dec_decim),
        .units_out      (dec_units),
        .fast_start_out (dec_fast)
    );

    // base unit is one 3200 Hz period
    assign period_cyc = 40'(dec_units) * 40'(BASE_CYCLES);
    // first delay: scaled decimation steps plus fixed part
    assign first_cyc  = 40'(dec_decim - 13'h1) * 40'(STEP_CYCLES) + 40'(FIRST_CYCLES);

    // ****************************************************************
    // acquisition sequencer
    // ****************************************************************
    // decimation is only sampled in LOAD, the period again at every sample;
    // changing them while active is the host's fault and takes effect only at the next LOAD or sample
    always_comb begin
        seq_nxt         = seq_r;
        applied_slp_nxt = applied_slp_r;
        count_nxt       = (count_r != 40'h0) ? count_r - 40'h1 : count_r;
        sample_nxt      = 1'b0;
        decim_nxt       = decim_r;
        if (!ctrl_r[`WSRS_CTRL_ACTIVE_BIT]) begin
            seq_nxt   = WSRS_SEQ_IDLE;
            count_nxt = 40'h0;
        end else begin
            unique case (seq_r)
                WSRS_SEQ_IDLE: begin
                    applied_slp_nxt = sleep_state_in;
                    seq_nxt         = WSRS_SEQ_LOAD;
                end
                WSRS_SEQ_LOAD: begin
                    decim_nxt = dec_decim;
                    seq_nxt   = WSRS_SEQ_FIRST;
                    count_nxt = dec_fast ? first_cyc : period_cyc;
                end
                WSRS_SEQ_FIRST, WSRS_SEQ_RUN: begin
                    if (sleep_state_in != applied_slp_r) begin
                        seq_nxt   = WSRS_SEQ_GAP;
                        count_nxt = 40'(GAP_CYCLES);
                    end else if (count_r == 40'h1) begin
                        sample_nxt = 1'b1;
                        seq_nxt    = WSRS_SEQ_RUN;
                        count_nxt  = period_cyc;
                    end
                end
                WSRS_SEQ_GAP: begin
                    if (count_r == 40'h1) begin
                        applied_slp_nxt = sleep_state_in;
                        seq_nxt         = WSRS_SEQ_LOAD;
                    end
                end
                // codes 101 to 111 cannot arise
                default: seq_nxt = WSRS_SEQ_IDLE;
            endcase
        end
    end

    // sequencer flip-flops
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            seq_r         <= WSRS_SEQ_IDLE;
            applied_slp_r <= 1'b0;
            count_r       <= 40'h0;
            sample_r      <= 1'b0;
            decim_r       <= 13'h1;
        end else begin
            seq_r         <= seq_nxt;
            applied_slp_r <= applied_slp_nxt;
            count_r       <= count_nxt;
            sample_r      <= sample_nxt;
            decim_r       <= decim_nxt;
        end
    end

    assign sample_ready_event_out = sample_r;
    assign acquiring_out          = (seq_r != WSRS_SEQ_IDLE);
    assign cur_decim_out          = decim_r;

    // ****************************************************************
    // data-ready interrupt pin
    // ****************************************************************
    // stretched low pulse when strapped high
    wsrs_pulse_stretch #(
        .PULSE_CYCLES (PULSE_CYCLES)
    ) u_pulse (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .trig_in       (sample_r & ctrl_r[`WSRS_CTRL_SAMPLE_READY_EVENT_EN_BIT]),
        .stretch_en_in (strap_r),
        .pulse_n_out   (interrupt_line_one_n_out)
    );

endmodule : wsrs_rate_select

// ===== wsrs_rate_select_sva.sv
// wsrs_rate_select_sva.sv: port checks of the rate select block.
// assumes the bind below and a shortened interrupt pulse count.
`timescale 1ns/100ps
module wsrs_rate_select_sva #(parameter int unsigned PULSE_CYCLES = 7)(
    // watched ports
    input wire logic clk_in, sys_rst_in, hsel_in, hwrite_in, hready_in,
    input wire logic [1:0] htrans_in,
    input wire logic hreadyout_out, hresp_out, boot_select_pin_in,
    input wire logic [31:0] hrdata_out,
    input wire logic sleep_state_in, interrupt_line_one_n_out,
    input wire logic sample_ready_event_out, acquiring_out,
    input wire logic [12:0] cur_decim_out
);
    int unsigned low_cnt; // edges at which the interrupt pin was seen low
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) low_cnt <= 0;
        else low_cnt <= interrupt_line_one_n_out ? 0 : low_cnt + 1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_bus_okay: assert property (hreadyout_out && !hresp_out) else $error("bus stall");
    a_decim_pow: assert property ($onehot(cur_decim_out)) else $error("bad decim");
    a_idle_quiet: assert property (!acquiring_out && !$past(acquiring_out)
        |-> !sample_ready_event_out) else $error("sample while idle");
    a_sample_single: assert property (sample_ready_event_out
        |=> !sample_ready_event_out) else $error("long sample");
    a_first_wait: assert property ($rose(acquiring_out)
        |-> !sample_ready_event_out [*5]) else $error("early first");
    a_int_cause: assert property ($fell(interrupt_line_one_n_out)
        |-> $past(sample_ready_event_out)) else $error("stray irq");
    a_pulse_long: assert property ($rose(interrupt_line_one_n_out) && boot_select_pin_in
        |-> low_cnt >= PULSE_CYCLES) else $error("short pulse");
    a_pulse_short: assert property ($fell(interrupt_line_one_n_out) && !boot_select_pin_in
        |=> interrupt_line_one_n_out) else $error("long pulse");
    a_rdata_hold: assert property (!(hsel_in && htrans_in[1] && hready_in && !hwrite_in)
        |=> $stable(hrdata_out)) else $error("rdata moved");
    a_gap_quiet: assert property (acquiring_out && $changed(sleep_state_in)
        |=> ##1 !sample_ready_event_out [*5]) else $error("no gap");
endmodule : wsrs_rate_select_sva
bind wsrs_rate_select wsrs_rate_select_sva #(.PULSE_CYCLES(PULSE_CYCLES)) wsrs_sva_inst (
    .clk_in, .sys_rst_in, .hsel_in, .hwrite_in, .hready_in, .htrans_in, .hreadyout_out,
    .hresp_out, .boot_select_pin_in, .hrdata_out, .sleep_state_in,
    .interrupt_line_one_n_out, .sample_ready_event_out, .acquiring_out, .cur_decim_out);

// ===== wsrs_host_model.sv
// wsrs_host_model.sv: host processor, single-word ahb-lite master.
// assumes one slave whose hreadyout comes back as hready_in.
`timescale 1ns/100ps
module wsrs_host_model (
    input  wire logic        clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    output logic             hsel_out,
    output logic [31:0]      haddr_out,
    output logic [1:0]       htrans_out,
    output logic             hwrite_out,
    output logic [2:0]       hsize_out,
    output logic [31:0]      hwdata_out
);
    initial begin // quiet bus at time zero
        {hsel_out, haddr_out, htrans_out, hwrite_out, hwdata_out} = '0;
        hsize_out = 3'h2;
    end
    task xfer(input logic w, input logic [7:0] i, input logic [31:0] wd,
              output logic [31:0] rd);
        @(posedge clk_in);
        hsel_out <= 1'b1; haddr_out <= {22'h0, i, 2'h0};
        hwrite_out <= w; htrans_out <= 2'h2;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        htrans_out <= 2'h0; hwdata_out <= wd;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        rd = hrdata_in;
    endtask : xfer
endmodule : wsrs_host_model

// ===== wsrs_rate_select_test.sv
// wsrs_rate_select_test.sv: self-checking bench of the rate select block.
// assumes short timing parameters: base 4, step 3, first 6, gap 5, pulse 7.
`timescale 1ns/100ps
`define CHK(s, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", s, e, g); end end
module wsrs_rate_select_test;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, pin = 1'b0, slp = 1'b0;
    logic hsel, hwrite, hrdy, hresp, irq_n, smp, acq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [12:0] dec;
    int n_errors = 0, checks = 0;
    always #5 clk_in = ~clk_in;
    wsrs_rate_select #(.BASE_CYCLES(4), .STEP_CYCLES(3), .FIRST_CYCLES(6), .GAP_CYCLES(5),
        .PULSE_CYCLES(7)) wsrs_rate_select_inst (.clk_in, .sys_rst_in, .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
        .hrdata_out(hrdata), .boot_select_pin_in(pin), .sleep_state_in(slp),
        .interrupt_line_one_n_out(irq_n), .sample_ready_event_out(smp),
        .acquiring_out(acq), .cur_decim_out(dec));
    wsrs_host_model wsrs_host_model_inst (.clk_in, .hready_in(hrdy), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
        .hsize_out(hsize), .hwdata_out(hwdata));
    task xf(input logic w, input logic [7:0] i, input logic [31:0] d, output logic [31:0] r);
        wsrs_host_model_inst.xfer(w, i, d, r);
    endtask : xf
    task rd(input logic [7:0] i, input logic [31:0] e, input string s);
        logic [31:0] r;
        xf(1'b0, i, 32'h0, r);
        `CHK(s, e, r)
    endtask : rd
    task next_sample(output int n); // edges until the next sample pulse
        n = 0;
        do begin @(posedge clk_in); n++; end while (smp !== 1'b1 && n < 40000);
    endtask : next_sample
    task irq_len(output int n); // edges the interrupt pin stays low, plus one
        n = 0;
        do begin @(posedge clk_in); n++; end while (irq_n === 1'b0 && n < 20);
    endtask : irq_len
    task run(input logic [7:0] pw, rt, il, input logic [12:0] de, input int f, p);
        logic [31:0] r;
        int n;
        xf(1'b1, 8'h15, 32'h0, r);
        xf(1'b1, 8'h16, {24'h0, pw}, r);
        xf(1'b1, 8'h17, {24'h0, rt}, r);
        xf(1'b1, 8'h30, {24'h0, il}, r);
        xf(1'b1, 8'h15, 32'h3, r);
        do @(posedge clk_in); while (acq !== 1'b1);
        next_sample(n);
        `CHK("first", f + 1, n)
        next_sample(n);
        `CHK("period", p, n)
        `CHK("decim", de, dec)
    endtask : run
    task t_regs;
        logic [31:0] r;
        rd(8'h17, 32'h0, "rate reset");
        xf(1'b1, 8'h17, 32'hA5, r);
        rd(8'h17, 32'hA5, "rate back");
        rd(8'h3F, 32'h0, "unmapped");
    endtask : t_regs
    task t_modes;
        int n;
        run(8'h00, 8'h00, 8'h0, 13'h1, 6, 4);
        irq_len(n);
        `CHK("pulse short", 2, n)
        run(8'h40, 8'h20, 8'h0, 13'h4, 16, 16);
        run(8'h40, 8'hE0, 8'h0, 13'h1000, 16384, 16384);
        run(8'h80, 8'h10, 8'h2, 13'h2, 24, 24);
        run(8'hC0, 8'h30, 8'h0, 13'h8, 27, 32);
    endtask : t_modes
    task t_gap;
        logic [31:0] r;
        int n;
        run(8'h10, 8'h02, 8'h0, 13'h1, 6, 4);
        slp <= 1'b1;
        next_sample(n);
        `CHK("sleep gap", 24, n)
        `CHK("sleep decim", 13'h4, dec)
        slp <= 1'b0;
        next_sample(n);
        `CHK("wake gap", 14, n)
        `CHK("wake decim", 13'h1, dec)
    endtask : t_gap
    task t_strap;
        int n;
        pin <= 1'b1;
        sys_rst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        rd(8'h17, 32'hC0, "rate strap");
        // strapped host stays in low power
        run(8'h00, 8'h50, 8'h0, 13'h1, 128, 128);
        irq_len(n);
        `CHK("pulse long", 8, n)
    endtask : t_strap
    task results;
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_regs; t_modes; t_gap; t_strap;
        results;
    end
    initial begin // watchdog
        #1000000;
        n_errors++;
        results;
    end
endmodule : wsrs_rate_select_test
